// *** hw/bdm_pkg.sv ***
// Shared constants and types of the background debug serial port.
package bdm_pkg;
    // ----------------------------------------
    // Timing, in target clocks
    // ----------------------------------------
    localparam int CNT_W = 10;
    localparam int TC_CYCLES = 1; // clk_sys is the target clock.
    localparam int BIT_TC = 16;
    localparam int SAMPLE_TC = 10;
    localparam int SPEEDUP1_TC = 7;
    localparam int ZERO_LOW_TC = 13;
    localparam int TIMEOUT_TC = 512;
    localparam logic [CNT_W-1:0] BIT_CNT = CNT_W'(BIT_TC * TC_CYCLES);
    localparam logic [CNT_W-1:0] SAMPLE_CNT = CNT_W'(SAMPLE_TC * TC_CYCLES);
    localparam logic [CNT_W-1:0] SPEEDUP1_CNT = CNT_W'(SPEEDUP1_TC * TC_CYCLES);
    localparam logic [CNT_W-1:0] ZERO_LOW_CNT = CNT_W'(ZERO_LOW_TC * TC_CYCLES);
    localparam logic [CNT_W-1:0] TIMEOUT_CNT = CNT_W'(TIMEOUT_TC * TC_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    // ----------------------------------------
    // Framing and commands
    // ----------------------------------------
    localparam int OPC_W = 8;
    localparam int WORD_W = 16;
    localparam logic [4:0] TX_BITS = 5'h10;
    localparam logic [2:0] LAST_RX_BIT = 3'h7;
    localparam logic [OPC_W-1:0] OPC_STEP = 8'h10;
    localparam logic [OPC_W-1:0] OPC_TAGGO = 8'h18;
    localparam logic [1:0] STRAP_SYNC = 2'h2;
    // ----------------------------------------
    // Synchronised input vector
    // ----------------------------------------
    localparam int IN_W = 5;
    localparam int IN_PIN = 0;
    localparam int IN_SCK = 1;
    localparam int IN_SI = 2;
    localparam int IN_EXTERNAL_BUS_CLOCK = 3;
    localparam int IN_TAG_LOW_PIN = 4;
    localparam logic [IN_W-1:0] IN_IDLE = 5'h1F;
    typedef enum logic [1:0] {ST_IDLE, ST_BIT} link_e;
    typedef enum logic [1:0] {CMD_STEP, CMD_TAGGO, CMD_OTHER} cmd_e;
endpackage

// *** hw/bdm_fifo.sv ***
// Shift-register FIFO with registered head, valid and ready on both sides.
module bdm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic in_valid, // Write request.
    input wire logic [WIDTH-1:0] in_data, // Write data.
    output logic in_ready, // Room for a word.
    output logic out_valid, // Head word present.
    output logic [WIDTH-1:0] out_data, // Head word.
    input wire logic out_ready // Drain side accepts the head.
);
    localparam int CW = $clog2(DEPTH + 1);
    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("bdm_fifo: DEPTH must be at least 2 and WIDTH at least 1");
        end
    end
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0] cnt;
        logic full;
        logic nempty;
    } fifo_s;
    fifo_s r_reg;
    fifo_s r_next;
    logic push;
    logic pop;
    assign push = in_valid && !r_reg.full;
    assign pop = out_ready && r_reg.nempty;
    // The head always sits in word 0, so the outputs are flops, not a read mux.
    always_comb begin
        r_next = r_reg;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                r_next.mem[i] = r_reg.mem[i+1];
            end
        end
        if (push) begin
            r_next.mem[pop ? r_reg.cnt - 1'b1 : r_reg.cnt] = in_data;
        end
        r_next.cnt = r_reg.cnt + CW'(push) - CW'(pop);
        r_next.full = (r_next.cnt == CW'(DEPTH));
        r_next.nempty = (r_next.cnt != '0);
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
    assign in_ready = !r_reg.full;
    assign out_valid = r_reg.nempty;
    assign out_data = r_reg.mem[0];
endmodule

// *** hw/bdm_serial_port.sv ***
// Background debug serial port: one-wire and SPI link, stepping and tagging.
// Operation
// - Debug pin is a mode strap at reset, serial pin afterwards.
// - One-wire bit lasts 16 target clocks, most significant bit first.
// - Transfer abandoned after 512 target clocks without host falling edge.
// - Received bit sampled ten target clocks after recognised falling edge.
// - Device sends one as a speedup pulse seven clocks after start.
// - Device sends zero as 13 clocks low then a speedup pulse.
// - SPI: SCK idles high, shift on falling, sample on rising edge.
// - Single-step leaves debug, runs one instruction, re-enters debug.
// - Pending interrupt on single-step: stack only, then back to debug.
// - Tag travels through queue; tagged head instruction enters debug.
// - Tagging off on debug entry; no commands while tagging active.
// - Tag pins sampled on bus clock fall; low level tags its byte.
// - High tags always; low tags only with low-byte strobe enabled.
// - Command is 8-bit opcode, then optional 16-bit address and data.
// - Single-step opcode 10 hex, tag-and-go opcode 18 hex.
module bdm_serial_port #(
    parameter int TAG_DEPTH = 3,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_sys, // Target clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic spi_mode, // Link select: 1 SPI, 0 one-wire.
    input wire logic debug_pin_in, // Debug pin level seen at the pad.
    output logic debug_pin_out, // Debug pin drive level.
    output logic debug_pin_oe_n, // Debug pin drive enable, low drives.
    input wire logic debug_serial_clock, // SPI clock from host.
    input wire logic spi_si, // SPI serial input.
    output logic spi_so, // SPI serial output.
    input wire logic tag_low_pin, // Low tag pin.
    input wire logic external_bus_clock, // Bus clock for tag sampling.
    input wire logic low_byte_strobe_en, // Low-byte strobe enabled.
    output logic special_mode, // Strap caught after reset.
    input wire logic expect_opcode, // Next byte is an opcode.
    output logic rx_valid, // Received byte available.
    output logic [bdm_pkg::OPC_W-1:0] rx_data, // Received byte.
    input wire logic rx_ready, // Consumer takes the byte.
    input wire logic tx_valid, // Read word offered.
    input wire logic [bdm_pkg::WORD_W-1:0] tx_word, // Read word.
    output logic tx_ready, // Word accepted when valid.
    input wire logic debug_request, // Enter active debug.
    input wire logic cpu_irq_pending, // Interrupt pending in CPU.
    input wire logic cpu_instr_done, // User instruction retired.
    input wire logic cpu_stack_done, // Interrupt stacking finished.
    input wire logic cpu_queue_advance, // Instruction queue shifts.
    output logic active_debug, // Active debug mode.
    output logic step_go, // Run one user instruction.
    output logic irq_stack, // Stack interrupt without instruction.
    output logic cpu_resume, // Resume user program.
    output logic tag_break, // Tagged instruction reached head.
    output logic tagging // Tagging enabled.
);
    import bdm_pkg::*;
    initial begin
        if (TAG_DEPTH < 1 || FIFO_DEPTH < 2) begin
            $error("bdm_serial_port: TAG_DEPTH >= 1 and FIFO_DEPTH >= 2 required");
        end
    end
    typedef struct packed {
        logic [IN_W-1:0] in1;
        logic [IN_W-1:0] in2;
        logic [IN_W-1:0] in3;
        link_e st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] gap;
        logic [2:0] rxn;
        logic [OPC_W-1:0] rx_sh;
        logic [WORD_W-1:0] tx_sh;
        logic [4:0] tx_left;
        logic tx_rdy;
        logic drv_out;
        logic drv_oe_n;
        logic so;
        logic byte_vld;
        logic [OPC_W-1:0] byte_val;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic special;
        logic active;
        logic stepping;
        logic step_go;
        logic irq_stack;
        logic resume;
        logic tag_en;
        logic tag_break;
        logic [1:0] pend;
        logic [TAG_DEPTH-1:0][1:0] tq;
    } state_s;
    state_s r_reg;
    state_s r_next;
    logic fifo_rdy;
    logic [IN_W-1:0] fall;
    logic [IN_W-1:0] rise;
    logic run;
    logic txa;

    function automatic cmd_e cmd_of(input logic [OPC_W-1:0] b);
        if (b == OPC_STEP) begin
            return CMD_STEP;
        end else if (b == OPC_TAGGO) begin
            return CMD_TAGGO;
        end
        return CMD_OTHER;
    endfunction

    // Edges come from the second and third stages only.
    assign fall = r_reg.in3 & ~r_reg.in2;
    assign rise = ~r_reg.in3 & r_reg.in2;
    // A full FIFO stalls the engine: new bits are ignored until it drains.
    assign run = r_reg.strap_done && !r_reg.tag_en && fifo_rdy;
    assign txa = (r_reg.tx_left != '0);

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic got;
        logic [OPC_W-1:0] byte_in;
        got = 1'b0;
        byte_in = '0;
        r_next = r_reg;
        r_next.in1 = {tag_low_pin, external_bus_clock, spi_si, debug_serial_clock, debug_pin_in};
        r_next.in2 = r_reg.in1;
        r_next.in3 = r_reg.in2;
        r_next.byte_vld = 1'b0;
        r_next.step_go = 1'b0;
        r_next.irq_stack = 1'b0;
        r_next.resume = 1'b0;
        r_next.tag_break = 1'b0;
        // The strap is caught once the synchroniser holds post-reset samples.
        if (!r_reg.strap_done) begin
            r_next.strap_cnt = r_reg.strap_cnt + 1'b1;
            if (r_reg.strap_cnt == STRAP_SYNC) begin
                r_next.strap_done = 1'b1;
                r_next.special = !r_reg.in2[IN_PIN];
            end
        end
        if (!spi_mode) begin
            if (r_reg.gap != TIMEOUT_CNT) begin
                r_next.gap = r_reg.gap + CNT_ONE;
            end
            case (r_reg.st)
                ST_IDLE: begin
                    if (fall[IN_PIN] && run) begin
                        r_next.st = ST_BIT;
                        r_next.cnt = CNT_ONE;
                        r_next.gap = CNT_ONE;
                        if (txa && !r_reg.tx_sh[WORD_W-1]) begin
                            r_next.drv_oe_n = 1'b0;
                            r_next.drv_out = 1'b0;
                        end
                    end else if (r_reg.gap == TIMEOUT_CNT - CNT_ONE) begin
                        r_next.rxn = '0;
                        r_next.tx_left = '0;
                    end
                end
                ST_BIT: begin
                    r_next.cnt = r_reg.cnt + CNT_ONE;
                    if (txa && r_reg.tx_sh[WORD_W-1]) begin
                        if (r_reg.cnt == SPEEDUP1_CNT - CNT_ONE) begin
                            r_next.drv_out = 1'b1;
                            r_next.drv_oe_n = 1'b0;
                        end else if (r_reg.cnt == SPEEDUP1_CNT) begin
                            r_next.drv_oe_n = 1'b1;
                        end
                    end else if (txa) begin
                        if (r_reg.cnt == ZERO_LOW_CNT - CNT_ONE) begin
                            r_next.drv_out = 1'b1;
                        end else if (r_reg.cnt == ZERO_LOW_CNT) begin
                            r_next.drv_oe_n = 1'b1;
                            r_next.drv_out = 1'b0;
                        end
                    end else if (r_reg.cnt == SAMPLE_CNT) begin
                        got = (r_reg.rxn == LAST_RX_BIT);
                        byte_in = {r_reg.rx_sh[OPC_W-2:0], r_reg.in2[IN_PIN]};
                        r_next.rx_sh = byte_in;
                        r_next.rxn = r_reg.rxn + 1'b1;
                    end
                    if (r_reg.cnt == BIT_CNT - CNT_ONE) begin
                        r_next.st = ST_IDLE;
                        if (txa) begin
                            r_next.tx_sh = r_reg.tx_sh << 1;
                            r_next.tx_left = r_reg.tx_left - 1'b1;
                        end
                    end
                end
                default: begin
                    r_next.st = ST_IDLE;
                end
            endcase
        end else begin
            r_next.st = ST_IDLE;
            r_next.drv_oe_n = 1'b1;
            if (rise[IN_SCK] && run) begin
                if (txa) begin
                    r_next.tx_sh = r_reg.tx_sh << 1;
                    r_next.tx_left = r_reg.tx_left - 1'b1;
                end else begin
                    got = (r_reg.rxn == LAST_RX_BIT);
                    byte_in = {r_reg.rx_sh[OPC_W-2:0], r_reg.in2[IN_SI]};
                    r_next.rx_sh = byte_in;
                    r_next.rxn = r_reg.rxn + 1'b1;
                end
            end
            if (fall[IN_SCK]) begin
                r_next.so = txa ? r_reg.tx_sh[WORD_W-1] : 1'b1;
            end
        end
        // ----------------------------------------
        // Command decode and debug mode
        // ----------------------------------------
        if (got) begin
            if (expect_opcode && r_reg.active && cmd_of(byte_in) == CMD_STEP) begin
                r_next.active = 1'b0;
                r_next.stepping = 1'b1;
                if (cpu_irq_pending) begin
                    r_next.irq_stack = 1'b1;
                end else begin
                    r_next.step_go = 1'b1;
                end
            end else if (expect_opcode && r_reg.active && cmd_of(byte_in) == CMD_TAGGO) begin
                r_next.active = 1'b0;
                r_next.tag_en = 1'b1;
                r_next.resume = 1'b1;
            end else begin
                r_next.byte_vld = 1'b1;
                r_next.byte_val = byte_in;
            end
        end
        if (r_reg.stepping && (cpu_instr_done || cpu_stack_done)) begin
            r_next.stepping = 1'b0;
            r_next.active = 1'b1;
        end
        if (debug_request) begin
            r_next.active = 1'b1;
            r_next.tag_en = 1'b0;
        end
        // ----------------------------------------
        // Tag capture and queue
        // ----------------------------------------
        if (cpu_queue_advance) begin
            for (int i = 0; i < TAG_DEPTH - 1; i++) begin
                r_next.tq[i] = r_reg.tq[i+1];
            end
            r_next.tq[TAG_DEPTH-1] = r_reg.pend;
            r_next.pend = '0;
        end
        if (r_reg.tag_en && fall[IN_EXTERNAL_BUS_CLOCK]) begin
            r_next.pend[1] = !r_reg.in2[IN_PIN];
            r_next.pend[0] = !r_reg.in2[IN_TAG_LOW_PIN] && low_byte_strobe_en;
        end
        if (r_reg.tag_en && r_reg.tq[0] != 2'h0) begin
            r_next.active = 1'b1;
            r_next.tag_en = 1'b0;
            r_next.tag_break = 1'b1;
            r_next.tq = '0;
            r_next.pend = '0;
        end
        // ----------------------------------------
        // Read word load
        // ----------------------------------------
        if (tx_valid && r_reg.tx_rdy) begin
            r_next.tx_sh = tx_word;
            r_next.tx_left = TX_BITS;
            r_next.so = tx_word[WORD_W-1];
        end
        r_next.tx_rdy = (r_next.tx_left == '0) && r_reg.strap_done;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.in1 <= IN_IDLE;
            r_reg.in2 <= IN_IDLE;
            r_reg.in3 <= IN_IDLE;
            r_reg.drv_oe_n <= 1'b1;
            r_reg.so <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    bdm_fifo #(
        .WIDTH(OPC_W),
        .DEPTH(FIFO_DEPTH)
    ) rx_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(r_reg.byte_vld),
        .in_data(r_reg.byte_val),
        .in_ready(fifo_rdy),
        .out_valid(rx_valid),
        .out_data(rx_data),
        .out_ready(rx_ready)
    );

    assign debug_pin_out = r_reg.drv_out;
    assign debug_pin_oe_n = r_reg.drv_oe_n;
    assign spi_so = r_reg.so;
    assign special_mode = r_reg.special;
    assign tx_ready = r_reg.tx_rdy;
    assign active_debug = r_reg.active;
    assign step_go = r_reg.step_go;
    assign irq_stack = r_reg.irq_stack;
    assign cpu_resume = r_reg.resume;
    assign tag_break = r_reg.tag_break;
    assign tagging = r_reg.tag_en;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence zero_low_s;
        (!r_reg.drv_oe_n && !r_reg.drv_out) [*8] ##4 (!r_reg.drv_oe_n && !r_reg.drv_out);
    endsequence
    sequence zero_pulse_s;
        (!r_reg.drv_oe_n && r_reg.drv_out) ##1 r_reg.drv_oe_n;
    endsequence
    sequence bit_start_s;
        !spi_mode && r_reg.st == ST_IDLE && r_next.st == ST_BIT;
    endsequence

    strap_hold_a: assert property (r_reg.strap_done |=> $stable(r_reg.special))
        else $error("strap value changed after capture");
    bit_len_a: assert property (bit_start_s |-> ##15 r_reg.st == ST_BIT ##1 r_reg.st == ST_IDLE)
        else $error("one-wire bit time is not 16 clocks");
    zero_bit_a: assert property ((bit_start_s and txa && !r_reg.tx_sh[WORD_W-1] && !spi_mode)
        |=> zero_low_s ##1 zero_pulse_s)
        else $error("logic zero not held low for 13 clocks");
    one_bit_a: assert property ((!spi_mode && r_reg.st == ST_BIT && txa && r_reg.tx_sh[WORD_W-1]
        && r_reg.cnt == 10'h006) |=> (!r_reg.drv_oe_n && r_reg.drv_out) ##1 r_reg.drv_oe_n)
        else $error("speedup pulse not at clock seven");
    timeout_a: assert property ((!spi_mode && r_reg.st == ST_IDLE && r_reg.gap == 10'h1FF
        && !(fall[IN_PIN] && run)) |=> r_reg.rxn == 3'h0 && r_reg.tx_left == 5'h00)
        else $error("transfer not abandoned after 512 idle clocks");
    sample_a: assert property ((!spi_mode && r_reg.st == ST_BIT && !txa && r_reg.cnt == 10'h00A)
        |=> r_reg.rx_sh[0] == $past(r_reg.in2[IN_PIN]))
        else $error("received bit not sampled at clock ten");
    step_a: assert property ($rose(r_reg.step_go) |-> !r_reg.active && r_reg.stepping
        && !r_reg.irq_stack)
        else $error("single step left debug state inconsistent");
    irq_step_a: assert property (r_reg.irq_stack |-> $past(cpu_irq_pending) && !r_reg.step_go)
        else $error("interrupt stacking without pending interrupt");
    tag_off_a: assert property ($rose(r_reg.active) |-> !r_reg.tag_en)
        else $error("tagging still on in active debug");
    tag_head_a: assert property ((r_reg.tag_en && r_reg.tq[0] != 2'h0)
        |=> r_reg.active && r_reg.tag_break ##1 !r_reg.tag_break)
        else $error("tagged head did not enter debug");
    low_tag_a: assert property ((r_reg.tag_en && fall[IN_EXTERNAL_BUS_CLOCK] && !low_byte_strobe_en)
        |=> !r_reg.pend[0])
        else $error("low tag accepted without low-byte strobe");
endmodule

// *** bench/host_model.sv ***
// Debug host pod model for the one-wire pin and the SPI link.
module host_model (
    input wire logic clk_sys, // Target clock.
    input wire logic debug_pin_out, // Device drive level.
    input wire logic debug_pin_oe_n, // Device drive enable, low drives.
    output logic debug_pin_in, // Resolved pin level.
    output logic debug_serial_clock, // SPI clock, idles high.
    output logic spi_si, // SPI serial input.
    input wire logic spi_so // SPI serial output of the device.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic host_low = 1'b0;
    initial debug_serial_clock = 1'b1;
    initial spi_si = 1'b1;
    // Pull-up on the pin: a released pin reads high.
    assign debug_pin_in = !debug_pin_oe_n ? debug_pin_out : !host_low;
    task automatic send_bit(input logic b);
        host_low <= 1'b1;
        repeat (b ? 4 : 12) @(posedge clk_sys);
        host_low <= 1'b0;
        repeat (b ? 16 : 8) @(posedge clk_sys);
    endtask
    task automatic recv_bit(output logic b);
        host_low <= 1'b1;
        repeat (2) @(posedge clk_sys);
        host_low <= 1'b0;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        b = debug_pin_in;
        repeat (10) @(posedge clk_sys);
    endtask
    task automatic send_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) send_bit(v[i]);
    endtask
    task automatic recv_word(output logic [15:0] w);
        for (int i = 15; i >= 0; i--) recv_bit(w[i]);
    endtask
    // SI changes while SCK is low so it is settled at the rising edge.
    // SO is taken just before the rising edge, where the device holds it valid.
    task automatic spi_bits(input int n, input logic [15:0] v, output logic [15:0] r);
        r = '0;
        #1;
        for (int i = n - 1; i >= 0; i--) begin
            debug_serial_clock = 1'b0;
            spi_si = v[i];
            #24;
            r[i] = spi_so;
            debug_serial_clock = 1'b1;
            #24;
        end
        spi_si = 1'b1;
    endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking testbench of the background debug serial port.
module testbench;
    import bdm_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0, rst = 1'b1, spi_mode = 1'b0, tag_low_pin = 1'b1;
    logic external_bus_clock = 1'b1, low_byte_strobe_en = 1'b1, expect_opcode = 1'b0;
    logic rx_ready = 1'b1, tx_valid = 1'b0, debug_request = 1'b0, cpu_irq_pending = 1'b0;
    logic cpu_instr_done = 1'b0, cpu_stack_done = 1'b0, cpu_queue_advance = 1'b0;
    logic [15:0] tx_word = 16'h0000, got;
    logic [7:0] rx_data, v;
    logic debug_pin_in, debug_pin_out, debug_pin_oe_n, sck, spi_si, spi_so, special_mode;
    logic rx_valid, tx_ready, active_debug, step_go, irq_stack, cpu_resume, tag_break, tagging;
    int num_errors = 0, checked = 0, seed = 32'h1de2;
    logic [7:0] byte_q[$];
    logic [3:0] ev_q[$];
    logic [7:0] exp_b;
    logic [3:0] exp_e, ev;
    always #2.5 clk_sys = ~clk_sys;
    host_model i_host (.clk_sys(clk_sys), .debug_pin_out(debug_pin_out),
        .debug_pin_oe_n(debug_pin_oe_n), .debug_pin_in(debug_pin_in),
        .debug_serial_clock(sck), .spi_si(spi_si), .spi_so(spi_so));
    bdm_serial_port i_dut (.clk_sys(clk_sys), .rst(rst), .spi_mode(spi_mode),
        .debug_pin_in(debug_pin_in), .debug_pin_out(debug_pin_out),
        .debug_pin_oe_n(debug_pin_oe_n), .debug_serial_clock(sck), .spi_si(spi_si),
        .spi_so(spi_so), .tag_low_pin(tag_low_pin), .external_bus_clock(external_bus_clock),
        .low_byte_strobe_en(low_byte_strobe_en), .special_mode(special_mode),
        .expect_opcode(expect_opcode), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready),
        .debug_request(debug_request), .cpu_irq_pending(cpu_irq_pending),
        .cpu_instr_done(cpu_instr_done), .cpu_stack_done(cpu_stack_done),
        .cpu_queue_advance(cpu_queue_advance), .active_debug(active_debug),
        .step_go(step_go), .irq_stack(irq_stack), .cpu_resume(cpu_resume),
        .tag_break(tag_break), .tagging(tagging));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] act);
        checked++;
        if (act !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h got %h", what, exp, act);
        end
    endtask
    task automatic close_out();
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic load_tx();
        @(posedge clk_sys);
        for (int k = 0; k < 50 && !tx_ready; k++) @(posedge clk_sys);
        if (!tx_ready) num_errors++;
        tx_valid <= 1'b1;
        tx_word <= 16'($random(seed));
        @(posedge clk_sys);
        tx_valid <= 1'b0;
    endtask
    // ----------------------------------------
    // Output watcher, sampled mid-cycle
    // ----------------------------------------
    always @(negedge clk_sys) begin
        if (rx_valid && rx_ready) begin
            exp_b = byte_q.size() ? byte_q.pop_front() : 8'hXX;
            chk("rx_data", 16'(exp_b), 16'(rx_data));
        end
        ev = {tag_break, cpu_resume, irq_stack, step_go};
        if (ev != 4'h0) begin
            exp_e = ev_q.size() ? ev_q.pop_front() : 4'hX;
            chk("cpu_event", 16'(exp_e), 16'(ev));
        end
    end
    initial begin
        #400000;
        num_errors++;
        close_out();
    end
    task automatic do_reset(input logic low);
        i_host.host_low <= low;
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("special_mode", 16'(low), 16'(special_mode));
        i_host.host_low <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        do_reset(1'b1);
        do_reset(1'b0);
        v = 8'($random(seed));
        byte_q.push_back(v);
        i_host.send_byte(v);
        // A broken byte must be dropped once the gap runs out.
        for (int i = 0; i < 3; i++) i_host.send_bit(1'b0);
        repeat (600) @(posedge clk_sys);
        byte_q.push_back(8'h5A);
        i_host.send_byte(8'h5A);
        load_tx();
        i_host.recv_word(got);
        chk("tx_word", tx_word, got);
        expect_opcode <= 1'b1;
        debug_request <= 1'b1;
        @(posedge clk_sys);
        debug_request <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            cpu_irq_pending <= (k == 1);
            ev_q.push_back(4'h1 << k);
            i_host.send_byte(k == 2 ? OPC_TAGGO : OPC_STEP);
            repeat (4) @(posedge clk_sys);
            cpu_instr_done <= (k == 0);
            cpu_stack_done <= (k == 1);
            @(posedge clk_sys);
            cpu_instr_done <= 1'b0;
            cpu_stack_done <= 1'b0;
            repeat (2) @(posedge clk_sys);
            chk("active_debug", 16'(k != 2), 16'(active_debug));
        end
        chk("tagging", 16'h0001, 16'(tagging));
        tag_low_pin <= 1'b0;
        low_byte_strobe_en <= 1'b0;
        ev_q.push_back(4'h8);
        for (int k = 0; k < 5; k++) begin
            i_host.host_low <= (k == 1);
            external_bus_clock <= 1'b0;
            repeat (5) @(posedge clk_sys);
            external_bus_clock <= 1'b1;
            cpu_queue_advance <= 1'b1;
            @(posedge clk_sys);
            cpu_queue_advance <= 1'b0;
            repeat (3) @(posedge clk_sys);
            if (k == 2) chk("tagging", 16'h0001, 16'(tagging));
        end
        chk("tag_state", 16'h0002, 16'({active_debug, tagging}));
        tag_low_pin <= 1'b1;
        spi_mode <= 1'b1;
        expect_opcode <= 1'b0;
        repeat (4) @(posedge clk_sys);
        v = 8'($random(seed));
        byte_q.push_back(v);
        i_host.spi_bits(8, 16'(v), got);
        load_tx();
        repeat (25) @(posedge clk_sys);
        i_host.spi_bits(16, 16'hFFFF, got);
        chk("spi_so", tx_word, got);
        for (int k = 0; k < 400 && (byte_q.size() || ev_q.size()); k++) @(posedge clk_sys);
        if (byte_q.size() || ev_q.size()) num_errors++;
        close_out();
    end
endmodule
